// ==== bench/usf_peer.sv ====
// Line-side model: frame strobes with their status bits, a bit tick, an idle-high line.
// Assumes a one-cycle go pulse with the frame word fr = {parity, stop, noise, data}.
`timescale 1ns/10ps
module usf_peer
(
	input wire logic CORE_CLK,
	input wire logic go,
	input wire logic [11:0] fr,
	output logic RX_FRAME_DONE,
	output logic [8:0] RX_FRAME_DATA,
	output logic RX_NOISE,
	output logic RX_STOP_BIT,
	output logic RX_PARITY_BIT,
	output logic RXD,
	output logic RX_BIT_TICK
);
	logic [11:0] h = 12'h000;
	logic [1:0] c = 2'h0;
	logic d = 1'h0;
	assign RX_FRAME_DONE = d;
	assign {RX_PARITY_BIT, RX_STOP_BIT, RX_NOISE, RX_FRAME_DATA} = h;
	assign RX_BIT_TICK = c == 2'h3;
	assign RXD = 1'h1;
	// Frame fields are only valid with the strobe; otherwise they toggle so stale values show.
	always @(posedge CORE_CLK)
	begin
		d <= go;
		h <= go ? fr : ~h;
		c <= c + 2'h1;
	end
endmodule

// ==== bench/usf_status_flags_checker.sv ====
// Port-level checks for the status flag block.
// Assumes it is bound into usf_status_flags; one clock, synchronous reset.
`timescale 1ns/10ps
module usf_checker
	import usf_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TX_BUSY,
	input wire logic TX_SERIAL,
	input wire logic TXD,
	input wire logic RX_BLOCKED,
	input wire logic RX_IRQ
);
	logic [7:0] ctl_r;
	logic acc;
	logic unm;
	assign acc = PSEL && PENABLE;
	assign unm = PADDR != USF_OFS_STATUS_ONE && PADDR != USF_OFS_DATA_HIGH
		&& PADDR != USF_OFS_DATA_LOW && PADDR != USF_OFS_CONTROL;
	// Mirror of the control register, so the enable can be judged without peeking inside.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			ctl_r <= USF_CONTROL_RST;
		else if (acc && PWRITE && PADDR == USF_OFS_CONTROL)
			ctl_r <= PWDATA[7:0];
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	a_ready_high: assert property (PSEL |-> PREADY)
		else $error("ready low in a transfer");
	a_status_read: assert property (acc && PADDR == USF_OFS_STATUS_ONE |-> !PSLVERR)
		else $error("status access refused");
	a_unmapped_err: assert property (acc && unm |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
	a_err_only_access: assert property (!acc |-> !PSLVERR)
		else $error("error outside access");
	a_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
		else $error("read data moved");
	a_txd_idle: assert property ($fell(RST) |-> TXD)
		else $error("line not idle after reset");
	a_txd_busy: assert property (TX_BUSY && $past(TX_BUSY) && $past(TX_BUSY, 2)
		|-> TXD == $past(TX_SERIAL)) else $error("line forced while sending");
	a_block_hold: assert property (RX_BLOCKED && !(acc && !PWRITE && PADDR == USF_OFS_DATA_LOW)
		|=> RX_BLOCKED) else $error("block dropped early");
	a_irq_mask: assert property (!ctl_r[USF_CTL_RIE] && !$past(ctl_r[USF_CTL_RIE]) |-> !RX_IRQ)
		else $error("request while disabled");
endmodule
bind usf_status_flags usf_checker i_chk(.*);

// ==== bench/usf_status_flags_tb.sv ====
// Self-checking bench: software over APB, transmitter strobes, line model.
// Assumes usf_peer answers frame requests and the checker is bound.
`timescale 1ns/10ps
module usf_status_flags_tb;
	import usf_pkg::*;
	localparam logic [11:0] st = USF_OFS_STATUS_ONE;
	localparam logic [11:0] dl = USF_OFS_DATA_LOW;
	localparam logic [11:0] cr = USF_OFS_CONTROL;
	logic CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0, err;
	logic TX_SHIFT_LOAD = 0, TX_QUEUED = 0, TX_BUSY = 0, TX_SERIAL = 0, RX_WAKEUP = 0;
	logic PREADY, PSLVERR, TXD, RXD, RX_BIT_TICK, RX_FRAME_DONE, RX_NOISE;
	logic RX_STOP_BIT, RX_PARITY_BIT, RX_BLOCKED, RX_IRQ;
	logic [8:0] RX_FRAME_DATA;
	logic [11:0] PADDR = 0, fr = 0;
	logic [31:0] PWDATA = 0, PRDATA, rd;
	int n_mismatch = 0, samples_checked = 0;
	usf_status_flags i_dut(.*);
	usf_peer i_peer(.*);
	always #12.5 CORE_CLK = ~CORE_CLK;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		// The answer is taken once settled, before the edge that completes the access.
		do
		begin
			@(negedge CORE_CLK);
			rdy = PREADY;
			rd = PRDATA;
			err = PSLVERR;
			@(posedge CORE_CLK);
		end
		while (rdy !== 1'h1);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CORE_CLK);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic send(input logic [11:0] f);
		fr <= f;
		go <= 1'h1;
		@(posedge CORE_CLK);
		go <= 1'h0;
		repeat (3) @(posedge CORE_CLK);
	endtask
	task automatic t_regs;
		chk(TXD, 32'h1);
		rdc(st, 32'hFFFFFFFF, 32'hC0);
		apb(1'h1, st, 32'hFF);
		rdc(st, 32'hFFFFFFFF, 32'hC0);
		apb(1'h0, 12'h020, 32'h0);
		chk(err, 32'h1);
	endtask
	task automatic t_tx;
		apb(1'h1, dl, 32'h5A);
		rdc(st, 32'hC0, 32'h00);
		TX_BUSY <= 1'h1;
		TX_SHIFT_LOAD <= 1'h1;
		@(posedge CORE_CLK);
		TX_SHIFT_LOAD <= 1'h0;
		repeat (3) @(posedge CORE_CLK);
		chk(TXD, 32'h0);
		rdc(st, 32'hC0, 32'h80);
		TX_BUSY <= 1'h0;
		repeat (2) @(posedge CORE_CLK);
		rdc(st, 32'hC0, 32'hC0);
		chk(TXD, 32'h1);
		// Queue while the line is quiet, so the set and the clear meet at one edge.
		TX_QUEUED <= 1'h1;
		@(posedge CORE_CLK);
		TX_QUEUED <= 1'h0;
		TX_BUSY <= 1'h1;
		@(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk(TXD, 32'h0);
		@(posedge CORE_CLK);
		rdc(st, 32'hC0, 32'h80);
		TX_BUSY <= 1'h0;
	endtask
	task automatic t_rx;
		apb(1'h1, cr, 32'h04);
		send(12'h455);
		chk(RX_IRQ, 32'h1);
		apb(1'h0, dl, 32'h0);
		rdc(st, 32'h2F, 32'h20);
		rdc(dl, 32'hFF, 32'h55);
		rdc(st, 32'h2F, 32'h00);
		send(12'h4A1);
		send(12'h612);
		rdc(st, 32'h2F, 32'h28);
		rdc(dl, 32'hFF, 32'hA1);
		rdc(st, 32'h2F, 32'h00);
		chk(RX_IRQ, 32'h0);
	endtask
	task automatic t_err;
		apb(1'h1, cr, 32'h08);
		send(12'h201);
		rdc(st, 32'h2F, 32'h27);
		chk(RX_BLOCKED, 32'h1);
		rdc(dl, 32'hFF, 32'h01);
		rdc(st, 32'h2F, 32'h00);
		chk(RX_BLOCKED, 32'h0);
	endtask
	task automatic t_idle;
		apb(1'h1, cr, 32'h01);
		send(12'h500);
		rdc(st, 32'h20, 32'h20);
		rdc(USF_OFS_DATA_HIGH, 32'h80, 32'h80);
		apb(1'h0, dl, 32'h0);
		repeat (80) @(posedge CORE_CLK);
		rdc(st, 32'h30, 32'h10);
		// The next frame lands before idle is cleared, so no frame follows the clear.
		send(12'h433);
		apb(1'h0, dl, 32'h0);
		repeat (80) @(posedge CORE_CLK);
		rdc(st, 32'h30, 32'h20);
		apb(1'h0, dl, 32'h0);
		apb(1'h1, cr, 32'h02);
		send(12'h433);
		rdc(st, 32'h20, 32'h20);
		apb(1'h0, dl, 32'h0);
		repeat (80) @(posedge CORE_CLK);
		rdc(st, 32'h10, 32'h00);
		RX_WAKEUP <= 1'h1;
		@(posedge CORE_CLK);
		RX_WAKEUP <= 1'h0;
		rdc(cr, 32'h02, 32'h00);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		give_verdict;
	end
	initial
	begin
		repeat (4) @(posedge CORE_CLK);
		RST <= 1'h0;
		@(posedge CORE_CLK);
		t_regs;
		t_tx;
		t_rx;
		t_err;
		t_idle;
		give_verdict;
	end
endmodule

// ==== logic/usf_pkg.sv ====
// Constants for the serial status flag block: register map, bit positions, reset values.
// Assumes a 32-bit APB master on CORE_CLK and strobes from transmitter and receiver.
// How it works
// - Apart from transmit-complete, a flag clears only after a status read saw it, then the data access.
// - Status register one sits at 0x0004, readable anytime, writes ignored.
// - Transmit-empty (bit 7) sets when the shifter takes the data word.
// - Transmit-empty clears by status read then low data byte write.
// - Transmit-complete (bit 6) low while sending; high when empty and nothing queued.
// - While transmit-complete is set the transmit line idles high.
// - Transmit-complete clears by read-then-write, or when anything is queued.
// - Simultaneous set and clear of transmit-complete leaves it cleared.
// - Receive-full (bit 5) sets on frame transfer; clears by read then data read.
// - Idle (bit 4) sets after 10 ones (8-bit) or 11 ones (9-bit).
// - After idle clears, a new receive-full must occur before idle sets again.
// - Idle line does not set idle while wakeup standby is set.
// - Idle clears by status read then low data byte read.
// - Overrun (bit 3) sets on second frame stop; new data dropped.
// - Overrun clears by read then data read; extra dummy read may be needed.
// - Noise (bit 2) sets with receive-full, never on overrun.
// - Framing (bit 1) sets with receive-full, not on overrun; blocks reception.
// - Parity (bit 0) sets on mismatch when enabled, with receive-full, not overrun.
// - Noise, framing and parity clear by status read then low data read.
// - Word-length bit selects 9-bit format when set, 8-bit when clear.
// - Wakeup standby suppresses receiver interrupt requests until hardware clears it.
// - Receive interrupt enable lets receive-full or overrun request an interrupt.
package usf_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [11:0] USF_OFS_STATUS_ONE = 12'h004;
	localparam logic [11:0] USF_OFS_DATA_HIGH = 12'h006;
	localparam logic [11:0] USF_OFS_DATA_LOW = 12'h007;
	localparam logic [11:0] USF_OFS_CONTROL = 12'h010;
	// ---------------------------------------------------------------
	// Status bit positions
	// ---------------------------------------------------------------
	localparam int USF_BIT_TRANSMIT_EMPTY_FLAG = 7;
	localparam int USF_BIT_TC = 6;
	localparam int USF_BIT_RECEIVE_FULL_FLAG = 5;
	localparam int USF_BIT_IDLE = 4;
	localparam int USF_BIT_OVR = 3;
	localparam int USF_BIT_NOISE = 2;
	localparam int USF_BIT_FRAME = 1;
	localparam int USF_BIT_PAR = 0;
	// ---------------------------------------------------------------
	// Control bit positions (word-length, wakeup standby, interrupt enable, parity enable, parity type)
	// ---------------------------------------------------------------
	localparam int USF_CTL_NINE_BIT = 0;
	localparam int USF_CTL_RWU = 1;
	localparam int USF_CTL_RIE = 2;
	localparam int USF_CTL_PAR_EN = 3;
	localparam int USF_CTL_PAR_TYPE = 4;
	// ---------------------------------------------------------------
	// Reset values and counts
	// ---------------------------------------------------------------
	localparam logic [7:0] USF_STATUS_RST = 8'hC0;
	localparam logic [7:0] USF_CONTROL_RST = 8'h00;
	localparam logic [3:0] USF_IDLE_ONES_8 = 4'hA;
	localparam logic [3:0] USF_IDLE_ONES_9 = 4'hB;
endpackage

// ==== logic/usf_status_flags.sv ====
// Status flag register of an asynchronous serial port with two-step flag clearing.
// Assumes transmitter and receiver give one-cycle event strobes on CORE_CLK; RXD is async.
`timescale 1ns/10ps
module usf_status_flags
	import usf_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TX_SHIFT_LOAD,
	input wire logic TX_QUEUED,
	input wire logic TX_BUSY,
	input wire logic TX_SERIAL,
	output logic TXD,
	input wire logic RXD,
	input wire logic RX_BIT_TICK,
	input wire logic RX_FRAME_DONE,
	input wire logic [8:0] RX_FRAME_DATA,
	input wire logic RX_NOISE,
	input wire logic RX_STOP_BIT,
	input wire logic RX_PARITY_BIT,
	input wire logic RX_WAKEUP,
	output logic RX_BLOCKED,
	output logic RX_IRQ
);
	import usf_pkg::*;

	logic [7:0] status_r;
	logic [7:0] armed_r;
	logic [7:0] control_r;
	logic [8:0] rx_data_r;
	logic [3:0] ones_cnt_r;
	logic idle_allowed_r;
	logic rxd_meta_r;
	logic rxd_sync_r;
	logic [31:0] prdata_r;
	logic acc;
	logic wr;
	logic rd;
	logic status_rd;
	logic data_low_rd;
	logic data_low_wr;
	logic [7:0] set_ev;
	logic [7:0] clr_ev;
	logic rx_accept;
	logic rx_overrun;
	logic parity_bad;
	logic idle_hit;
	logic [3:0] idle_need;
	logic known_addr;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Every access finishes in its first access cycle, so no wait states.
	assign acc = PSEL && PENABLE;
	assign wr = acc && PWRITE;
	assign rd = acc && !PWRITE;
	assign status_rd = rd && (PADDR == USF_OFS_STATUS_ONE);
	assign data_low_rd = rd && (PADDR == USF_OFS_DATA_LOW);
	assign data_low_wr = wr && (PADDR == USF_OFS_DATA_LOW);
	assign known_addr = (PADDR == USF_OFS_STATUS_ONE) || (PADDR == USF_OFS_DATA_HIGH)
		|| (PADDR == USF_OFS_DATA_LOW) || (PADDR == USF_OFS_CONTROL);
	assign PREADY = 1'b1;
	assign PSLVERR = acc && !known_addr;
	assign PRDATA = prdata_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			prdata_r <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
		begin
			unique case (PADDR)
				USF_OFS_STATUS_ONE: prdata_r <= {24'h000000, status_r};
				USF_OFS_DATA_HIGH: prdata_r <= {24'h000000, rx_data_r[8], 7'h00};
				USF_OFS_DATA_LOW: prdata_r <= {24'h000000, rx_data_r[7:0]};
				USF_OFS_CONTROL: prdata_r <= {24'h000000, control_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Writes to the status register fall through here and have no effect.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			control_r <= USF_CONTROL_RST;
		else if (wr && (PADDR == USF_OFS_CONTROL))
			control_r <= PWDATA[7:0];
		else if (RX_WAKEUP)
			control_r[USF_CTL_RWU] <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Receive input synchroniser and idle counter
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			rxd_meta_r <= 1'b1;
			rxd_sync_r <= 1'b1;
		end
		else
		begin
			rxd_meta_r <= RXD;
			rxd_sync_r <= rxd_meta_r;
		end
	end

	assign idle_need = control_r[USF_CTL_NINE_BIT] ? USF_IDLE_ONES_9 : USF_IDLE_ONES_8;
	assign idle_hit = RX_BIT_TICK && rxd_sync_r && (ones_cnt_r == idle_need - 4'h1);

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			ones_cnt_r <= 4'h0;
		else if (RX_FRAME_DONE)
			ones_cnt_r <= 4'h0;
		else if (RX_BIT_TICK)
		begin
			if (!rxd_sync_r)
				ones_cnt_r <= 4'h0;
			else if (ones_cnt_r < idle_need)
				ones_cnt_r <= ones_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			idle_allowed_r <= 1'b0;
		else if (set_ev[USF_BIT_RECEIVE_FULL_FLAG])
			idle_allowed_r <= 1'b1;
		else if (clr_ev[USF_BIT_IDLE])
			idle_allowed_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Event decode
	// ---------------------------------------------------------------
	assign RX_BLOCKED = status_r[USF_BIT_FRAME];
	assign rx_accept = RX_FRAME_DONE && !RX_BLOCKED && !status_r[USF_BIT_RECEIVE_FULL_FLAG];
	assign rx_overrun = RX_FRAME_DONE && !RX_BLOCKED && status_r[USF_BIT_RECEIVE_FULL_FLAG];
	assign parity_bad = control_r[USF_CTL_PAR_EN]
		&& ((^RX_FRAME_DATA[7:0] ^ RX_PARITY_BIT) != control_r[USF_CTL_PAR_TYPE]);

	always_comb
	begin
		set_ev = 8'h00;
		set_ev[USF_BIT_TRANSMIT_EMPTY_FLAG] = TX_SHIFT_LOAD;
		set_ev[USF_BIT_TC] = (status_r[USF_BIT_TRANSMIT_EMPTY_FLAG] || TX_SHIFT_LOAD) && !TX_BUSY;
		set_ev[USF_BIT_RECEIVE_FULL_FLAG] = rx_accept;
		set_ev[USF_BIT_IDLE] = idle_hit && idle_allowed_r && !control_r[USF_CTL_RWU];
		set_ev[USF_BIT_OVR] = rx_overrun;
		set_ev[USF_BIT_NOISE] = rx_accept && RX_NOISE;
		set_ev[USF_BIT_FRAME] = rx_accept && !RX_STOP_BIT;
		set_ev[USF_BIT_PAR] = rx_accept && parity_bad;
	end

	// Clears fire only for flags whose status read armed them; transmit-complete also clears on TX_QUEUED or TX_BUSY.
	always_comb
	begin
		clr_ev = 8'h00;
		clr_ev[USF_BIT_TRANSMIT_EMPTY_FLAG] = data_low_wr && armed_r[USF_BIT_TRANSMIT_EMPTY_FLAG];
		clr_ev[USF_BIT_TC] = (data_low_wr && armed_r[USF_BIT_TC]) || TX_QUEUED || TX_BUSY;
		clr_ev[USF_BIT_RECEIVE_FULL_FLAG] = data_low_rd && armed_r[USF_BIT_RECEIVE_FULL_FLAG];
		clr_ev[USF_BIT_IDLE] = data_low_rd && armed_r[USF_BIT_IDLE];
		clr_ev[USF_BIT_OVR] = data_low_rd && armed_r[USF_BIT_OVR];
		clr_ev[USF_BIT_NOISE] = data_low_rd && armed_r[USF_BIT_NOISE];
		clr_ev[USF_BIT_FRAME] = data_low_rd && armed_r[USF_BIT_FRAME];
		clr_ev[USF_BIT_PAR] = data_low_rd && armed_r[USF_BIT_PAR];
	end

	// ---------------------------------------------------------------
	// Flags and arming records
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_flag
			always_ff @(posedge CORE_CLK)
			begin
				if (RST)
					status_r[gi] <= USF_STATUS_RST[gi];
				else if (gi == USF_BIT_TC)
					status_r[gi] <= clr_ev[gi] ? 1'b0 : (set_ev[gi] | status_r[gi]);
				else
					status_r[gi] <= set_ev[gi] | (status_r[gi] & ~clr_ev[gi]);
			end

			// A read arms a flag it saw set; a fresh set between steps keeps it armed.
			always_ff @(posedge CORE_CLK)
			begin
				if (RST)
					armed_r[gi] <= 1'b0;
				// Arm from the value the read returned; a flag that set after it was never seen.
				else if (status_rd && prdata_r[gi])
					armed_r[gi] <= 1'b1;
				else if (clr_ev[gi] || !status_r[gi])
					armed_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Receive data holding and outputs
	// ---------------------------------------------------------------
	// Overrun data is dropped; the held frame stays intact.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			rx_data_r <= 9'h000;
		else if (rx_accept)
			rx_data_r <= RX_FRAME_DATA;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			TXD <= 1'b1;
		else
			TXD <= status_r[USF_BIT_TC] ? 1'b1 : TX_SERIAL;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			RX_IRQ <= 1'b0;
		else
			RX_IRQ <= control_r[USF_CTL_RIE] && !control_r[USF_CTL_RWU]
				&& (status_r[USF_BIT_RECEIVE_FULL_FLAG] || status_r[USF_BIT_OVR]);
	end
endmodule
